// >>> hw/srsup_pkg.sv
/*
  Package for the supply reset supervisor: timing constants, timeout
  select encoding and the packed structs that carry the monitor inputs
  and the supervisor outputs. Assumes a 250 MHz system clock.
*/
package srsup_pkg;

  // System clock period in picoseconds.
  localparam int unsigned CLK_PERIOD_PS = 4000;

  // Power-up reset hold times per timeout select code, in microseconds.
  localparam int unsigned HOLD_TIME_0_US = 50;
  localparam int unsigned HOLD_TIME_1_US = 100;
  localparam int unsigned HOLD_TIME_2_US = 200;
  localparam int unsigned HOLD_TIME_3_US = 400;

  // Cycle counts derived from the times; longest count fits 17 bits.
  localparam int unsigned HOLD_CYC_0 =
    HOLD_TIME_0_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned HOLD_CYC_1 =
    HOLD_TIME_1_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned HOLD_CYC_2 =
    HOLD_TIME_2_US * 1000000 / CLK_PERIOD_PS;
  localparam int unsigned HOLD_CYC_3 =
    HOLD_TIME_3_US * 1000000 / CLK_PERIOD_PS;

  localparam int unsigned CNT_W = 17;

  // Values after reset.
  localparam logic [16:0] CNT_RESET = 17'h00000;
  localparam logic [1:0]  SEL_RESET = 2'h0;

  // Comparator and manual reset inputs, all asynchronous to the clock.
  typedef struct packed {
    logic supply_ok;
    logic secondary_monitor_input;
    logic manual_reset_input;
  } srsup_mon_t;

  // Supervisor outputs, open drain: enables pull low.
  typedef struct packed {
    logic reset_oe;
    logic secondary_monitor_flag_oe;
  } srsup_out_t;

  // Enables after reset: reset pin released (reads active), flag pulled low.
  localparam srsup_out_t OE_RESET = 2'h1;

endpackage : srsup_pkg

// >>> hw/srsup_top.sv
/*
  Supply reset supervisor output logic. Drives the open-drain reset pin
  and the secondary monitor flag pin from synchronised comparator results.
  Assumes the comparators and manual reset arrive asynchronously and that
  external pull-ups make the pin high when the enable is low.
  The timeout select bits come from logic on the same clock and are read
  live, so the host must not expect a select change to wait for a new
  power-up sequence.
*/
`timescale 1ns/1ns
module srsup_top (
  // Clock and reset.
  input  wire logic                clk_sys_in,
  input  wire logic                nrst_in,
  // Comparator results and manual reset, asynchronous.
  input  wire srsup_pkg::srsup_mon_t mon_in,
  // Timeout select bits from the internal control register.
  input  wire logic                reset_timeout_select_lo_in,
  input  wire logic                reset_timeout_select_hi_in,
  // Open-drain pins: level driven when enable low is released.
  output logic                     reset_out,
  output logic                     reset_oe_out,
  output logic                     secondary_monitor_flag_out,
  output logic                     secondary_monitor_flag_oe_out
);

  // Maps a timeout select code to its hold count.
  function automatic logic [16:0] hold_cycles(input logic [1:0] sel);
    case (sel)
      2'h0:    hold_cycles = 17'(srsup_pkg::HOLD_CYC_0);
      2'h1:    hold_cycles = 17'(srsup_pkg::HOLD_CYC_1);
      2'h2:    hold_cycles = 17'(srsup_pkg::HOLD_CYC_2);
      default: hold_cycles = 17'(srsup_pkg::HOLD_CYC_3);
    endcase
  endfunction : hold_cycles

  typedef enum logic [1:0] {ST_HOLD, ST_COUNT, ST_RUN} srsup_state_t;

  logic [2:0]   sync1_reg;
  logic [2:0]   sync2_reg;
  logic [2:0]   sync1_next;
  logic [2:0]   sync2_next;
  srsup_state_t state_reg;
  srsup_state_t state_next;
  logic [16:0]  cnt_reg;
  logic [16:0]  cnt_next;
  logic         rst_reg;
  logic         rst_next;
  logic         flag_reg;
  logic         flag_next;
  logic         supply_ok;
  logic         mr_act;
  logic         sec_above;
  logic [1:0]   sel;
  // Pin drive registers; the level flop only ever holds zero.
  srsup_pkg::srsup_out_t out_oe_reg;
  srsup_pkg::srsup_out_t out_oe_next;
  logic         pin_lvl_reg;
  logic         pin_lvl_next;

  // Two-stage synchronisers; only the second stage feeds logic.
  // The first stage may go metastable, so nothing else may read it.
  always_comb begin
    sync1_next = {mon_in.supply_ok, mon_in.secondary_monitor_input,
                  mon_in.manual_reset_input};
    sync2_next = sync1_reg;
  end

  assign supply_ok = sync2_reg[2];
  assign sec_above = sync2_reg[1];
  assign mr_act    = sync2_reg[0];
  assign sel       = {reset_timeout_select_hi_in, reset_timeout_select_lo_in};

  // Reset sequencer: any bad condition sends it back to hold.
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg;
    rst_next   = 1'b1;
    flag_next  = sec_above;
    if (!supply_ok || mr_act) begin
      state_next = ST_HOLD;
      cnt_next   = srsup_pkg::CNT_RESET;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          state_next = ST_COUNT;
          cnt_next   = srsup_pkg::CNT_RESET;
        end
        ST_COUNT: begin
          // Select is read live, so a change mid-hold takes effect at once.
          if (cnt_reg + 17'h00001 >= hold_cycles(sel)) begin
            state_next = ST_RUN;
            rst_next   = 1'b0;
          end else begin
            cnt_next = cnt_reg + 17'h00001;
          end
        end
        ST_RUN:  rst_next = 1'b0;
        default: state_next = ST_HOLD;
      endcase
    end
  end

  // Register update; the supervisor powers up holding reset.
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      sync1_reg <= 3'h0;
      sync2_reg <= 3'h0;
      state_reg <= ST_HOLD;
      cnt_reg   <= srsup_pkg::CNT_RESET;
      rst_reg   <= 1'b1;
      flag_reg  <= 1'b0;
    end else begin
      sync1_reg <= sync1_next;
      sync2_reg <= sync2_next;
      state_reg <= state_next;
      cnt_reg   <= cnt_next;
      rst_reg   <= rst_next;
      flag_reg  <= flag_next;
    end
  end

  // Pin drive next values. The enables come from the same next values as
  // the sequencer, so the pins move on the same edge as the state while
  // every output still leaves the block straight from a flip-flop.
  always_comb begin
    out_oe_next.reset_oe                  = ~rst_next;
    out_oe_next.secondary_monitor_flag_oe = ~flag_next;
    pin_lvl_next                          = 1'b0;
  end

  // Pin drive registers; after reset the reset pin is released to its
  // pull-up, which shows reset active, and the flag pin is pulled low.
  always_ff @(posedge clk_sys_in) begin
    if (!nrst_in) begin
      out_oe_reg  <= srsup_pkg::OE_RESET;
      pin_lvl_reg <= 1'b0;
    end else begin
      out_oe_reg  <= out_oe_next;
      pin_lvl_reg <= pin_lvl_next;
    end
  end

  // Open drain: the enable pulls the pin low; the level stays zero so no
  // high level can ever fight the external pull-up.
  assign reset_out                     = pin_lvl_reg;
  assign secondary_monitor_flag_out    = pin_lvl_reg;
  assign reset_oe_out                  = out_oe_reg.reset_oe;
  assign secondary_monitor_flag_oe_out = out_oe_reg.secondary_monitor_flag_oe;

  // Conditions of the sequencer, shared by the properties below.
  sequence bad_cond_s;
    !supply_ok || mr_act;
  endsequence

  sequence good_cond_s;
    supply_ok && !mr_act;
  endsequence

  sequence count_busy_s;
    state_reg == ST_COUNT;
  endsequence

  // Checks on the synchronised inputs; they cannot see glitches that the
  // synchronisers themselves swallow.
  flag_follow_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    flag_reg == $past(sec_above))
    else $error("Secondary flag does not follow comparator.");

  flag_pin_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    secondary_monitor_flag_oe_out == !$past(sec_above))
    else $error("Secondary flag pin does not follow comparator.");

  flag_no_delay_a: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    $rose(sec_above) |=> !secondary_monitor_flag_oe_out)
    else $error("Secondary flag delayed.");

  flag_in_hold_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    rst_reg && $rose(sec_above) |=> !secondary_monitor_flag_oe_out)
    else $error("Secondary flag held back by reset hold.");

  reset_hold_pin_a: assert property (@(posedge clk_sys_in)
    disable iff (!nrst_in)
    bad_cond_s |=> !reset_oe_out [*2])
    else $error("Reset pin not active on bad condition.");

  supply_low_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    !supply_ok |=> rst_reg)
    else $error("Reset not active on low supply.");

  manual_force_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    mr_act |=> !reset_oe_out)
    else $error("Manual reset did not force reset.");

  hold_min_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    bad_cond_s ##1 good_cond_s |-> rst_reg [*8])
    else $error("Reset released before hold time.");

  count_step_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    count_busy_s ##0 good_cond_s ##0 (cnt_reg + 17'h00001 < hold_cycles(sel))
      |=> cnt_reg == $past(cnt_reg) + 17'h00001)
    else $error("Hold counter did not advance.");

  hold_restart_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    count_busy_s ##0 bad_cond_s
      |=> state_reg == ST_HOLD && cnt_reg == srsup_pkg::CNT_RESET)
    else $error("Hold not restarted by bad condition.");

  release_pin_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $rose(reset_oe_out) |-> $past(state_reg) == ST_COUNT)
    else $error("Reset pin released outside the hold count.");

  release_cond_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    $fell(rst_reg) |-> state_reg == ST_RUN
      && $past(cnt_reg) + 17'h00001 >= hold_cycles(sel))
    else $error("Reset released without full hold.");

  sel_count_a: assert property (@(posedge clk_sys_in) disable iff (!nrst_in)
    state_reg == ST_COUNT && $stable(sel)
      |-> cnt_reg < hold_cycles(sel))
    else $error("Hold counter exceeds selected timeout.");

endmodule : srsup_top

// >>> tb/srsup_host.sv
/*
  Host-side model of the two supervisor pins.
  Assumes both open-drain pins carry external pull-ups.
*/
`timescale 1ns/1ns
module srsup_host (
  // Pin levels and enables from the supervisor.
  input  wire logic rst_lvl_in,
  input  wire logic flag_lvl_in,
  input  wire logic rst_oe_in,
  input  wire logic flag_oe_in,
  // Resolved pin levels as the host sees them.
  output logic      rst_pin_out,
  output logic      flag_pin_out
);
  // The pull-up wins whenever the enable lets go of the pin.
  assign rst_pin_out  = rst_oe_in ? rst_lvl_in : 1'b1;
  assign flag_pin_out = flag_oe_in ? flag_lvl_in : 1'b1;
endmodule : srsup_host

// >>> tb/srsup_top_bench.sv
/*
  Self-checking bench for the supply reset supervisor.
  Assumes the host model resolves the open-drain pin levels.
*/
`timescale 1ns/1ns
module srsup_top_bench;
  logic                  clk_sys_in   = 1'b0;
  logic                  nrst_in      = 1'b0;
  srsup_pkg::srsup_mon_t mon          = 3'h4;
  logic [1:0]            sel          = 2'h0;
  logic                  rst_lvl;
  logic                  flag_lvl;
  logic                  rst_oe;
  logic                  flag_oe;
  logic                  rst_pin;
  logic                  flag_pin;
  int                    err_count    = 0;
  int                    total_checks = 0;

  // Free-running 250 MHz clock.
  always #2 clk_sys_in = ~clk_sys_in;

  srsup_top srsup_top_inst (.clk_sys_in(clk_sys_in), .nrst_in(nrst_in),
    .mon_in(mon), .reset_timeout_select_lo_in(sel[0]),
    .reset_timeout_select_hi_in(sel[1]), .reset_out(rst_lvl),
    .reset_oe_out(rst_oe), .secondary_monitor_flag_out(flag_lvl),
    .secondary_monitor_flag_oe_out(flag_oe));
  srsup_host srsup_host_inst (.rst_lvl_in(rst_lvl), .flag_lvl_in(flag_lvl),
    .rst_oe_in(rst_oe), .flag_oe_in(flag_oe),
    .rst_pin_out(rst_pin), .flag_pin_out(flag_pin));

  // Compares one pin level or release-timing result with its expectation and counts the outcome.
  task automatic check(input logic got, input logic exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("Error at %0t: pin level mismatch", $time);
    end
  endtask : check

  // Prints the counts and the verdict, then ends the run.
  task automatic wrap_up();
    $display("checks %0d errors %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : wrap_up

  // Counts cycles to release; synchroniser latency allows a few extra.
  task automatic wait_release(input int n);
    int cnt;
    cnt = 0;
    while (rst_pin === 1'b1 && cnt < n + 20) begin
      @(negedge clk_sys_in);
      cnt++;
    end
    check(cnt >= n && cnt <= n + 6, 1'b1);
  endtask : wait_release

  // Toggles the secondary input while reset is still held.
  task automatic flag_test();
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys_in);
      mon.secondary_monitor_input <= i[0];
      repeat (4) @(negedge clk_sys_in);
      check(flag_pin, i[0]);
    end
  endtask : flag_test

  // Trips reset by low supply or manual reset, then times the hold.
  task automatic trip_test(input logic [1:0] code, input int n,
                           input logic by_mr);
    @(posedge clk_sys_in);
    sel <= code;
    if (by_mr) mon.manual_reset_input <= 1'b1;
    else mon.supply_ok <= 1'b0;
    repeat (5) @(negedge clk_sys_in);
    check(rst_pin, 1'b1);
    @(posedge clk_sys_in);
    mon <= 3'h4;
    wait_release(n);
  endtask : trip_test

  // Code 3 must outlast the code 1 time; a live switch to 0 then ends it.
  task automatic sel_test();
    @(posedge clk_sys_in);
    sel <= 2'h3;
    mon.supply_ok <= 1'b0;
    repeat (5) @(posedge clk_sys_in);
    mon <= 3'h4;
    repeat (25100) @(negedge clk_sys_in);
    check(rst_pin, 1'b1);
    @(posedge clk_sys_in);
    sel <= 2'h0;
    wait_release(1);
  endtask : sel_test

  // Main sequence; the first trip lands mid-hold and must restart it.
  initial begin
    repeat (10) @(posedge clk_sys_in);
    nrst_in <= 1'b1;
    repeat (2) @(negedge clk_sys_in);
    check(rst_pin, 1'b1);
    flag_test();
    repeat (5000) @(posedge clk_sys_in);
    trip_test(2'h0, 12500, 1'b0);
    trip_test(2'h0, 12500, 1'b1);
    trip_test(2'h1, 25000, 1'b0);
    sel_test();
    wrap_up();
  end

  // Watchdog well past the expected run of about 80000 cycles.
  initial begin
    #(95000 * 4);
    err_count++;
    wrap_up();
  end
endmodule : srsup_top_bench
